// >>> sim/nic_command_register_test.sv
module nic_command_register_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  nic_cmd_pkg::nic_bus_req_t bus_req = '0;
  logic tx_start, tx_busy, tx_done, rdma_busy, rdma_abort, online, rst_done, page_res, dma_req;
  logic [7:0] rdata;
  logic [1:0] page;
  logic [2:0] rdma_cmd;
  logic [2:0] last_cmd = 3'h0;
  logic [1:0] ack = 2'h0;
  logic rx_busy = 1'b0;
  logic reload = 1'b1;
  logic cnt_zero, rdma_req_m;
  int fails = 0;
  int samples_checked = 0;
  int seed = 83;
  int starts = 0;
  int aborts = 0;
  always #10 core_clk = ~core_clk;
  // acknowledge pins wander at random, pulses are counted off the sampling edge
  always @(posedge core_clk) {rx_busy, ack} <= 3'($random(seed));
  always @(negedge core_clk) begin
    if (tx_start === 1'b1) starts++;
    if (rdma_abort === 1'b1) aborts++;
    if (rdma_cmd !== 3'h0) last_cmd = rdma_cmd;
  end
  nic_cmd_reg i_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req), .rdata_ff(rdata),
    .page_ff(page), .page_reserved_ff(page_res), .tx_start_ff(tx_start), .tx_busy(tx_busy),
    .tx_done(tx_done), .tx_abort(1'b0), .rx_busy(rx_busy), .rdma_start_ff(rdma_cmd),
    .rdma_abort_ff(rdma_abort), .rdma_busy(rdma_busy), .rdma_count_zero(cnt_zero),
    .rcount_reloaded(reload), .read_acknowledge_in(ack[0]), .write_acknowledge_in(ack[1]),
    .dma_request_out_ff(dma_req), .rdma_req(rdma_req_m), .online_ff(online),
    .reset_done_ff(rst_done));
  nic_eng_model i_eng (.core_clk(core_clk), .rstn(rstn), .tx_start(tx_start),
    .rdma_start(rdma_cmd), .rdma_abort(rdma_abort), .tx_busy(tx_busy), .tx_done(tx_done),
    .rdma_busy(rdma_busy), .rdma_count_zero(cnt_zero), .rdma_req(rdma_req_m));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: 4'h0, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic rd_chk(input string w, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: 4'h0, wdata: 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    repeat (2) @(posedge core_clk);
    #1 chk(w, e, rdata);
  endtask
  // bounded wait: 0 online, 1 reset done, 2 transmitter idle
  task automatic wait_hi(input int s);
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      #1;
      if ((s == 0 ? online : s == 1 ? rst_done : !tx_busy) === 1'b1) return;
    end
    fails++;
    $display("Error wait %0d expected 1 seen 0", s);
    end_of_test();
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd_chk("cmd after reset", 8'h01);
    wr(8'h02);
    wait_hi(0);
    rd_chk("cmd running", 8'h02);
    wr(8'h06);
    wr(8'h02);
    rd_chk("cmd transmit held", 8'h06);
    wait_hi(2);
    rd_chk("cmd transmit cleared", 8'h02);
    chk("transmit starts", 8'h01, 8'(starts));
    for (int c = 1; c < 4; c++) begin
      wr(8'(c * 8 + 2));
      repeat (2) @(posedge core_clk);
      chk("dma command", 8'(c), {5'h00, last_cmd});
      wr(8'h22);
    end
    // reissue of a running read with transmit and no count reload finishes it
    wr(8'h0A);
    reload <= 1'b0;
    wr(8'h0E);
    reload <= 1'b1;
    wait_hi(2);
    chk("transmit starts", 8'h02, 8'(starts));
    chk("dma aborts", 8'h04, 8'(aborts));
    // a read left to run out retires the field to complete
    wr(8'h0A);
    repeat (70) @(posedge core_clk);
    rd_chk("cmd dma retired", 8'h22);
    for (int p = 0; p < 4; p++) begin
      wr(8'(p * 64 + 34));
      repeat (3) @(posedge core_clk);
      #1 chk("page", 8'(p), {6'h00, page});
      chk("page reserved", 8'(p == 3), {7'h00, page_res});
      rd_chk("cmd page", 8'(p * 64 + 34));
    end
    wr(8'h23);
    rd_chk("cmd halt while running", 8'h23);
    wait_hi(1);
    chk("online", 8'h00, {7'h00, online});
    end_of_test();
  end
endmodule // nic_command_register_test

// >>> sim/nic_eng_model.sv
module nic_eng_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // requests from the command register
  input wire logic tx_start,
  input wire logic [2:0] rdma_start,
  input wire logic rdma_abort,
  // engine status
  output logic tx_busy,
  output logic tx_done,
  output logic rdma_busy,
  output logic rdma_count_zero,
  output logic rdma_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tx_cnt_ff;
  logic [5:0] rdma_cnt_ff;
  logic rdma_run_ff;
  // a long frame so a host write can land while it is still on the wire
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt_ff <= 4'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (tx_cnt_ff == 4'h1);
      if (tx_start)
        tx_cnt_ff <= 4'hF;
      else if (tx_cnt_ff != 4'h0)
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
    end
  end
  assign tx_busy = (tx_cnt_ff != 4'h0);
  // remote dma moves a fixed block; on abort the model zeroes the count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdma_run_ff <= 1'b0;
      rdma_cnt_ff <= 6'h00;
    end else if (rdma_abort) begin
      rdma_run_ff <= 1'b0;
      rdma_cnt_ff <= 6'h00;
    end else if (rdma_start != 3'h0) begin
      rdma_run_ff <= 1'b1;
      rdma_cnt_ff <= 6'h3F;
    end else if (rdma_cnt_ff != 6'h00) begin
      rdma_run_ff <= (rdma_cnt_ff != 6'h01);
      rdma_cnt_ff <= rdma_cnt_ff - 6'h01;
    end
  end
  // the start pulse already counts as busy, so the field is not retired early
  assign rdma_busy = rdma_run_ff || (rdma_start != 3'h0);
  assign rdma_count_zero = (rdma_cnt_ff == 6'h00);
  assign rdma_req = rdma_run_ff;
endmodule // nic_eng_model

// >>> src/nic_cmd_pkg.sv
package nic_cmd_pkg;
  typedef enum logic [2:0] {
    NIC_RD_NONE = 3'h0,
    NIC_RD_READ = 3'h1,
    NIC_RD_WRITE = 3'h2,
    NIC_RD_SEND = 3'h3
  } nic_rdma_t;
  typedef enum logic [2:0] {
    NIC_ST_STOPPED = 3'h1,
    NIC_ST_RUNNING = 3'h2,
    NIC_ST_DRAINING = 3'h4
  } nic_state_t;
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } nic_bus_req_t;
endpackage

// >>> src/nic_cmd_reg.sv
// Notes on behaviour
// - 8-bit command register at 00H, fixed fields
// - reissued dma with transmit, no reload: finish
// - zero written to transmit request ignored
// - page, abort, halt writable at any time
// - halt drops online at once, stops after current packet ends
// - leave stop only on halt clear, run set
// - reset-done flag set once reset took effect
// - halt bit set at power up
// - run bit low at power up
// - halt while running reads run and halt set
// - transmit request self-clears on done or abort
// - dma field decode 001/010/011, 1xx abort
// - abort stops dma, address not restored
// - aborted dma keeps request until acknowledge
// - page select chooses register page
// - page 00/01/10 decoded, 11 reserved
`include "nic_cmd_regs.svh"
module nic_cmd_reg (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // host register bus, same clock
  input wire nic_cmd_pkg::nic_bus_req_t bus_req,
  output logic [7:0] rdata_ff,
  output logic [1:0] page_ff,
  output logic page_reserved_ff,
  // transmit engine
  output logic tx_start_ff,
  input wire logic tx_busy,
  input wire logic tx_done,
  input wire logic tx_abort,
  input wire logic rx_busy,
  // remote dma engine
  output logic [2:0] rdma_start_ff,
  output logic rdma_abort_ff,
  input wire logic rdma_busy,
  input wire logic rdma_count_zero,
  input wire logic rcount_reloaded,
  // dma handshake pins, acknowledges asynchronous
  input wire logic read_acknowledge_in,
  input wire logic write_acknowledge_in,
  output logic dma_request_out_ff,
  input wire logic rdma_req,
  // controller state
  output logic online_ff,
  output logic reset_done_ff
);
  logic [1:0] ps_ff;
  logic [2:0] rd_ff;
  logic txreq_ff;
  logic run_ff;
  logic halt_ff;
  logic [1:0] rdack_sync_ff;
  logic [1:0] wrack_sync_ff;
  logic hold_req_ff;
  nic_cmd_pkg::nic_state_t state_ff;
  nic_cmd_pkg::nic_state_t nxt_state;
  logic cmd_wr;
  logic cmd_rd;
  logic [2:0] wr_rd;
  logic ack;

  // field extraction, used by decode and checks
  function automatic logic [2:0] rd_field(input logic [7:0] v);
    rd_field = v[`NIC_CMD_RDMA_MSB:`NIC_CMD_RDMA_LSB];
  endfunction

  assign cmd_wr = bus_req.wr && (bus_req.addr == `NIC_CMD_OFFSET);
  assign cmd_rd = bus_req.rd;
  assign wr_rd = rd_field(bus_req.wdata);
  assign ack = rdack_sync_ff[1] || wrack_sync_ff[1];

  // acknowledge pins come from outside, two flops each
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdack_sync_ff <= 2'h0;
      wrack_sync_ff <= 2'h0;
    end else begin
      rdack_sync_ff <= {rdack_sync_ff[0], read_acknowledge_in};
      wrack_sync_ff <= {wrack_sync_ff[0], write_acknowledge_in};
    end
  end

  // page select and dma field accepted whenever written
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ps_ff <= 2'(`NIC_CMD_RESET >> `NIC_CMD_PAGE_LSB);
      rd_ff <= 3'h0;
    end else if (cmd_wr) begin
      ps_ff <= bus_req.wdata[`NIC_CMD_PAGE_MSB:`NIC_CMD_PAGE_LSB];
      rd_ff <= wr_rd;
    end else if (!rd_ff[2] && rd_ff != 3'h0 && !rdma_busy && rdma_count_zero) begin
      rd_ff <= 3'h4; // finished dma reads as complete
    end
  end

  // page decode; page 3 flagged so other registers can refuse it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_ff <= 2'h0;
      page_reserved_ff <= 1'b0;
    end else begin
      page_ff <= ps_ff;
      page_reserved_ff <= (ps_ff == 2'h3);
    end
  end

  // transmit request: a written zero has no effect, hardware clears
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txreq_ff <= 1'b0;
      tx_start_ff <= 1'b0;
    end else begin
      tx_start_ff <= 1'b0;
      if (cmd_wr && bus_req.wdata[`NIC_CMD_TXREQ_POS] && !txreq_ff && !halt_ff && run_ff) begin
        txreq_ff <= 1'b1;
        tx_start_ff <= 1'b1;
      end else if (tx_done || tx_abort) begin
        txreq_ff <= 1'b0;
      end
    end
  end

  // remote dma commands; abort wins, reissue with transmit may finish
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdma_start_ff <= 3'h0;
      rdma_abort_ff <= 1'b0;
    end else begin
      rdma_start_ff <= 3'h0;
      rdma_abort_ff <= 1'b0;
      if (cmd_wr && wr_rd[2]) begin
        rdma_abort_ff <= 1'b1;
      end else if (cmd_wr && wr_rd != 3'h0) begin
        if (bus_req.wdata[`NIC_CMD_TXREQ_POS] && wr_rd == rd_ff && !rcount_reloaded) begin
          rdma_abort_ff <= 1'b1;
        end else if (wr_rd != rd_ff || rcount_reloaded) begin
          rdma_start_ff <= wr_rd;
        end
      end
    end
  end

  // request pin: an aborted dma leaves it high until acknowledged
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_req_ff <= 1'b0;
      dma_request_out_ff <= 1'b0;
    end else begin
      if (rdma_abort_ff && !rdma_count_zero && dma_request_out_ff) begin
        hold_req_ff <= 1'b1;
      end else if (ack) begin
        hold_req_ff <= 1'b0;
      end
      dma_request_out_ff <= (rdma_req || hold_req_ff) && !ack;
    end
  end

  // run and halt bits; halt leaves run set for readback
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt_ff <= 1'b1;
      run_ff <= 1'b0;
    end else if (cmd_wr) begin
      if (bus_req.wdata[`NIC_CMD_HALT_POS]) begin
        halt_ff <= 1'b1;
      end else if (bus_req.wdata[`NIC_CMD_RUN_POS]) begin
        halt_ff <= 1'b0;
        run_ff <= 1'b1;
      end
    end
  end

  // controller state: halt drains current packet before stopping
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      nic_cmd_pkg::NIC_ST_STOPPED: if (!halt_ff && run_ff) nxt_state = nic_cmd_pkg::NIC_ST_RUNNING;
      nic_cmd_pkg::NIC_ST_RUNNING: if (halt_ff) nxt_state = nic_cmd_pkg::NIC_ST_DRAINING;
      nic_cmd_pkg::NIC_ST_DRAINING: if (!tx_busy && !rx_busy) nxt_state = nic_cmd_pkg::NIC_ST_STOPPED;
      default: nxt_state = nic_cmd_pkg::NIC_ST_STOPPED;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= nic_cmd_pkg::NIC_ST_STOPPED;
      online_ff <= 1'b0;
      reset_done_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      online_ff <= (nxt_state == nic_cmd_pkg::NIC_ST_RUNNING);
      reset_done_ff <= (nxt_state == nic_cmd_pkg::NIC_ST_STOPPED);
    end
  end

  // read data registered; only the command register lives here
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h0;
    end else if (cmd_rd && bus_req.addr == `NIC_CMD_OFFSET) begin
      rdata_ff <= {ps_ff, rd_ff, txreq_ff, run_ff, halt_ff};
    end else if (cmd_rd) begin
      rdata_ff <= 8'h0;
    end
  end

  chk_halt_drain: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_ff == nic_cmd_pkg::NIC_ST_DRAINING && (tx_busy || rx_busy)) |=> !reset_done_ff)
    else $error("stopped while packet active");
  chk_run_exit: assert property (@(posedge core_clk) disable iff (!rstn)
    (state_ff == nic_cmd_pkg::NIC_ST_STOPPED && (halt_ff || !run_ff))
    |=> (state_ff == nic_cmd_pkg::NIC_ST_STOPPED))
    else $error("bad stop exit");
  chk_txreq_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (txreq_ff && cmd_wr && !bus_req.wdata[`NIC_CMD_TXREQ_POS] && !tx_done && !tx_abort)
    |=> txreq_ff)
    else $error("zero cleared transmit request");
  chk_txreq_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    ((tx_done || tx_abort) && !cmd_wr) |=> !txreq_ff)
    else $error("transmit request not cleared");
  chk_halt_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    (cmd_wr && bus_req.wdata[`NIC_CMD_HALT_POS]) |=> (halt_ff && run_ff == $past(run_ff)))
    else $error("halt write lost run state");
  chk_abort_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
    (cmd_wr && wr_rd[2]) |=> (rdma_abort_ff && rdma_start_ff == 3'h0))
    else $error("abort not issued");
  chk_req_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (hold_req_ff && !ack) |=> dma_request_out_ff)
    else $error("request dropped before acknowledge");
  chk_page_write: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_wr |=> ##1 (page_ff == $past(bus_req.wdata[7:6], 2)))
    else $error("page select not applied");
  chk_done_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    reset_done_ff |-> (state_ff == nic_cmd_pkg::NIC_ST_STOPPED))
    else $error("reset flag early");
endmodule // nic_cmd_reg

// >>> src/nic_cmd_regs.svh
`ifndef NIC_CMD_REGS_SVH
`define NIC_CMD_REGS_SVH
`define NIC_CMD_OFFSET 4'h0
`define NIC_CMD_RESET 8'h01
`define NIC_CMD_HALT_POS 0
`define NIC_CMD_RUN_POS 1
`define NIC_CMD_TXREQ_POS 2
`define NIC_CMD_RDMA_LSB 3
`define NIC_CMD_RDMA_MSB 5
`define NIC_CMD_PAGE_LSB 6
`define NIC_CMD_PAGE_MSB 7
`endif
